// ---- hdl/maint_defs.svh ----
// register offsets, field positions, reset values and pattern constants
// assumes inclusion by bare name from the design files
`ifndef MAINT_DEFS_SVH
`define MAINT_DEFS_SVH
`define ADDR_PATTERN_LOS 8'h2C
`define ADDR_CODE_LENGTH 8'h2D
`define ADDR_TX_CODE 8'h2E
`define ADDR_RX_ACT_CODE 8'h2F
`define ADDR_RX_DEACT_CODE 8'h30
`define ADDR_STATUS 8'h3F
`define PATT_HI 6
`define PATT_LO 5
`define PATTERN_CLOCK_SELECT_BIT 4
`define PRBS_INVERT_BIT 3
`define CRIT_BIT 2
`define RX_AIS_BIT 1
`define AUTO_ONES_BIT 0
`define TXLEN_HI 5
`define TXLEN_LO 4
`define ACTLEN_HI 3
`define ACTLEN_LO 2
`define DEACTLEN_HI 1
`define DEACTLEN_LO 0
`define RST_PATTERN_LOS 8'h00
`define RST_CODE_LENGTH 8'h01
`define RST_TX_CODE 8'h01
`define RST_RX_ACT_CODE 8'h01
`define RST_RX_DEACT_CODE 8'h09
`define PRBS15_SEED 15'h7FFF
`define QRSS20_SEED 20'hFFFFF
`define PATTERN_LOS_MASK 8'h7F
`define CODE_LENGTH_MASK 8'h3F
`endif

// ---- hdl/maint_pkg.sv ----
// types shared by the maintenance pattern block
// assumes the defines header is included by the user files
package maint_pkg;
    typedef enum logic [1:0] {
        PATT_NORMAL = 2'h0,
        PATT_ONES = 2'h1,
        PATT_PRBS = 2'h2,
        PATT_CODE = 2'h3
    } pattern_t;
    typedef enum logic [3:0] {
        SRC_DATA = 4'h1,
        SRC_ZERO = 4'h2,
        SRC_ONES = 4'h4,
        SRC_GEN = 4'h8
    } src_state_t;
endpackage

// ---- hdl/prbs_gen.sv ----
// pseudo-random generator: 2^15-1 in e1 mode, 2^20-1 qrss in t1/j1 mode
// assumes a one-cycle bit enable from the caller
`timescale 1ns/1ns
`include "maint_defs.svh"
module prbs_gen (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // control
    input wire logic bit_en,
    input wire logic e1_mode,
    input wire logic invert,
    // output
    output logic prbs_bit
);
    logic [14:0] p15_reg;
    logic [19:0] q20_reg;
    logic fb15;
    logic fb20;
    logic raw;
    logic q_bit;

    // x^15+x^14+1 and x^20+x^17+1 feedbacks
    assign fb15 = p15_reg[14] ^ p15_reg[13];
    assign fb20 = q20_reg[19] ^ q20_reg[16];
    // qrss forces a one after fourteen zeros in a row
    assign q_bit = (q20_reg[13:0] == 14'h0000) ? 1'b1 : q20_reg[19];
    assign raw = e1_mode ? p15_reg[14] : q_bit;
    assign prbs_bit = raw ^ invert;

    // both shift together so mode changes need no reseed
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            p15_reg <= `PRBS15_SEED;
            q20_reg <= `QRSS20_SEED;
        end else if (bit_en) begin
            p15_reg <= {p15_reg[13:0], fb15};
            q20_reg <= {q20_reg[18:0], fb20};
        end
    end
endmodule

// ---- hdl/code_gen.sv ----
// repeats the low 5..8 bits of an inband code, highest selected bit first
// assumes a one-cycle bit enable from the caller
`timescale 1ns/1ns
module code_gen (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // control
    input wire logic run,
    input wire logic bit_en,
    input wire logic [1:0] code_len,
    input wire logic [7:0] code,
    // output
    output logic code_bit
);
    logic [2:0] idx_reg;
    logic [2:0] idx_next;
    logic [2:0] top_idx;

    // length 00..11 gives top index 4..7
    assign top_idx = {1'b0, code_len} + 3'h4;
    assign idx_next = (idx_reg == 3'h0) ? top_idx : idx_reg - 3'h1;
    assign code_bit = code[idx_reg];

    // restart at the top when idle so every burst starts on the msb
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            idx_reg <= 3'h4;
        end else if (!run) begin
            idx_reg <= top_idx;
        end else if (bit_en) begin
            idx_reg <= idx_next;
        end
    end
endmodule

// ---- hdl/line_maint_pattern_ctrl.sv ----
// maintenance register bank and transmit pattern selector for one channel
// assumes synchronous inputs and one-cycle bit enables for both ref clocks
`timescale 1ns/1ns
`include "maint_defs.svh"
module line_maint_pattern_ctrl (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    // line mode and bit enables
    input wire logic e1_mode,
    input wire logic tx_clock_en,
    input wire logic master_clock_en,
    // transmit stream
    input wire logic tx_data_in,
    output logic tx_data_out,
    output logic tx_bit_valid,
    // loss of signal and receive side
    input wire logic los,
    input wire logic rx_data_positive,
    input wire logic rx_data_negative,
    input wire logic channel_rx_clock,
    output logic rx_data_positive_out,
    output logic rx_data_negative_out,
    output logic channel_rx_clock_out,
    // settings toward the detectors
    output logic los_ais_criterion,
    output logic prbs_invert,
    output logic [1:0] rx_activate_code_length,
    output logic [1:0] rx_deactivate_code_length,
    output logic [7:0] rx_activate_code,
    output logic [7:0] rx_deactivate_code
);
    logic [7:0] pattern_los_reg;
    logic [7:0] code_length_reg;
    logic [7:0] tx_code_reg;
    logic [7:0] act_code_reg;
    logic [7:0] deact_code_reg;
    maint_pkg::src_state_t src_reg;
    maint_pkg::src_state_t src_next;
    logic [7:0] rdata_next;
    logic [7:0] rdata_reg;
    logic tx_out_reg;
    logic tx_valid_reg;
    logic rdp_reg;
    logic rdn_reg;
    logic rclk_reg;
    logic ais_phase_reg;

    // field views
    wire [1:0] pattern_select = pattern_los_reg[`PATT_HI:`PATT_LO];
    wire pattern_clock_select = pattern_los_reg[`PATTERN_CLOCK_SELECT_BIT];
    wire prbs_invert_w = pattern_los_reg[`PRBS_INVERT_BIT];
    wire crit_w = pattern_los_reg[`CRIT_BIT];
    wire rx_ais_enable = pattern_los_reg[`RX_AIS_BIT];
    wire auto_all_ones_on_los = pattern_los_reg[`AUTO_ONES_BIT];
    wire [1:0] tx_code_length = code_length_reg[`TXLEN_HI:`TXLEN_LO];

    // top bit index of a 5..8 bit code for a length field
    function automatic logic [2:0] code_top(input logic [1:0] len);
        return {1'h0, len} + 3'h4;
    endfunction

    // register address decode
    wire hit_patt = (addr == `ADDR_PATTERN_LOS);
    wire hit_len = (addr == `ADDR_CODE_LENGTH);
    wire hit_tx = (addr == `ADDR_TX_CODE);
    wire hit_act = (addr == `ADDR_RX_ACT_CODE);
    wire hit_deact = (addr == `ADDR_RX_DEACT_CODE);
    wire hit_stat = (addr == `ADDR_STATUS);

    // chosen reference clock paces every internal pattern
    wire bit_en = pattern_clock_select ? master_clock_en : tx_clock_en;
    wire pat_is_code = (pattern_select == maint_pkg::PATT_CODE);
    wire prbs_bit;
    wire code_bit;

    prbs_gen prbs_gen_inst (
        .clock(clock),
        .rst(rst),
        .bit_en(bit_en),
        .e1_mode(e1_mode),
        .invert(prbs_invert_w),
        .prbs_bit(prbs_bit)
    );

    code_gen code_gen_inst (
        .clock(clock),
        .rst(rst),
        .run(pat_is_code),
        .bit_en(bit_en),
        .code_len(tx_code_length),
        .code(tx_code_reg),
        .code_bit(code_bit)
    );

    // register writes; reserved bits are masked so they read as zero
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pattern_los_reg <= `RST_PATTERN_LOS;
            code_length_reg <= `RST_CODE_LENGTH;
            tx_code_reg <= `RST_TX_CODE;
            act_code_reg <= `RST_RX_ACT_CODE;
            deact_code_reg <= `RST_RX_DEACT_CODE;
        end else if (wr_en) begin
            if (hit_patt) pattern_los_reg <= wdata & `PATTERN_LOS_MASK;
            if (hit_len) code_length_reg <= wdata & `CODE_LENGTH_MASK;
            if (hit_tx) tx_code_reg <= wdata;
            if (hit_act) act_code_reg <= wdata;
            if (hit_deact) deact_code_reg <= wdata;
        end
    end

    // read mux; status shows the live source and los; unmapped reads zero
    assign rdata_next = hit_patt ? pattern_los_reg :
                        hit_len ? code_length_reg :
                        hit_tx ? tx_code_reg :
                        hit_act ? act_code_reg :
                        hit_deact ? deact_code_reg :
                        hit_stat ? {3'h0, los, src_reg} :
                        8'h00;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rd_en ? rdata_next : 8'h00;
        end
    end
    assign rdata = rdata_reg;

    // source selection; auto ones only acts in normal select
    always_comb begin
        src_next = maint_pkg::SRC_DATA;
        case (pattern_select)
            maint_pkg::PATT_NORMAL: begin
                if (auto_all_ones_on_los && los) begin
                    src_next = maint_pkg::SRC_ONES;
                end else if (pattern_clock_select) begin
                    src_next = maint_pkg::SRC_ZERO;
                end else begin
                    src_next = maint_pkg::SRC_DATA;
                end
            end
            maint_pkg::PATT_ONES: src_next = maint_pkg::SRC_ONES;
            maint_pkg::PATT_PRBS: src_next = maint_pkg::SRC_GEN;
            default: src_next = maint_pkg::SRC_GEN;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            src_reg <= maint_pkg::SRC_DATA;
        end else begin
            src_reg <= src_next;
        end
    end

    // normal data follows the tx clock; patterns follow the chosen clock
    wire out_en = (src_next == maint_pkg::SRC_DATA) ? tx_clock_en : bit_en;
    wire gen_bit = pat_is_code ? code_bit : prbs_bit;
    wire out_bit = (src_next == maint_pkg::SRC_DATA) ? tx_data_in :
                   (src_next == maint_pkg::SRC_ONES) ? 1'b1 :
                   (src_next == maint_pkg::SRC_ZERO) ? 1'b0 : gen_bit;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tx_out_reg <= 1'b0;
            tx_valid_reg <= 1'b0;
        end else begin
            tx_valid_reg <= out_en;
            if (out_en) tx_out_reg <= out_bit;
        end
    end
    assign tx_data_out = tx_out_reg;
    assign tx_bit_valid = tx_valid_reg;

    // ais is all ones marks; in dual rail alternate rails, clock at half rate
    wire ais_on = rx_ais_enable && los;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdp_reg <= 1'b0;
            rdn_reg <= 1'b0;
            rclk_reg <= 1'b0;
            ais_phase_reg <= 1'b0;
        end else if (ais_on) begin
            ais_phase_reg <= ~ais_phase_reg;
            rclk_reg <= ais_phase_reg;
            rdp_reg <= ais_phase_reg;
            rdn_reg <= ~ais_phase_reg;
        end else begin
            rdp_reg <= rx_data_positive;
            rdn_reg <= rx_data_negative;
            rclk_reg <= channel_rx_clock;
        end
    end
    assign rx_data_positive_out = rdp_reg;
    assign rx_data_negative_out = rdn_reg;
    assign channel_rx_clock_out = rclk_reg;

    // detector settings come straight from registers
    assign los_ais_criterion = crit_w;
    assign prbs_invert = prbs_invert_w;
    assign rx_activate_code_length = code_length_reg[`ACTLEN_HI:`ACTLEN_LO];
    assign rx_deactivate_code_length = code_length_reg[`DEACTLEN_HI:`DEACTLEN_LO];
    assign rx_activate_code = act_code_reg;
    assign rx_deactivate_code = deact_code_reg;

    // all ones pattern holds one on every valid bit
    ones_hold_a: assert property (@(posedge clock) disable iff (rst)
        (pattern_select == maint_pkg::PATT_ONES) ##1 tx_bit_valid |-> tx_data_out)
        else $error("all ones pattern broken");
    // zeros inserted with master clock in normal select
    zeros_hold_a: assert property (@(posedge clock) disable iff (rst)
        (pattern_select == 2'h0 && pattern_clock_select && !los && master_clock_en)
        |=> !tx_data_out)
        else $error("zero pattern broken");
    // normal data passes through one cycle later
    data_pass_a: assert property (@(posedge clock) disable iff (rst)
        (src_next == maint_pkg::SRC_DATA && tx_clock_en) |=> tx_data_out == $past(tx_data_in))
        else $error("normal data not passed");
    // auto ones on los in normal select
    auto_ones_a: assert property (@(posedge clock) disable iff (rst)
        (pattern_select == 2'h0 && auto_all_ones_on_los && los && tx_clock_en
         && !pattern_clock_select) |=> tx_data_out)
        else $error("auto ones missing");
    // ais marks the receive outputs during los
    ais_drive_a: assert property (@(posedge clock) disable iff (rst)
        (rx_ais_enable && los)[*2] |=> rx_data_positive_out != rx_data_negative_out)
        else $error("ais not inserted");
    // ais off means receive data passes
    ais_off_a: assert property (@(posedge clock) disable iff (rst)
        !rx_ais_enable |=> rx_data_positive_out == $past(rx_data_positive))
        else $error("receive data altered");
    // ones pattern bits follow the tx clock when it is the selected reference
    clock_pick_a: assert property (@(posedge clock) disable iff (rst)
        (pattern_select == 2'h1 && !pattern_clock_select) |=> tx_bit_valid == $past(tx_clock_en))
        else $error("wrong reference clock");
    // code msb is sent first after entering code mode
    code_first_a: assert property (@(posedge clock) disable iff (rst)
        ($rose(pat_is_code) && bit_en) |=> tx_data_out ==
            $past(tx_code_reg[code_top(tx_code_length)]))
        else $error("code not msb first");
    // reset defaults of code registers
    code_reset_a: assert property (@(posedge clock)
        $fell(rst) |-> tx_code_reg == 8'h01 && act_code_reg == 8'h01 && deact_code_reg == 8'h09
            && code_length_reg == 8'h01)
        else $error("reset defaults wrong");
    // detector invert follows register
    inv_follow_a: assert property (@(posedge clock) disable iff (rst)
        (wr_en && hit_patt) |=> prbs_invert == $past(wdata[3]))
        else $error("invert bit not applied");
    // length fields written land in place
    len_write_a: assert property (@(posedge clock) disable iff (rst)
        (wr_en && hit_len) |=> tx_code_length == $past(wdata[5:4])
            && rx_activate_code_length == $past(wdata[3:2]))
        else $error("length write lost");
    // generator bit reaches the line on each chosen enable
    prbs_path_a: assert property (@(posedge clock) disable iff (rst)
        (pattern_select == maint_pkg::PATT_PRBS && bit_en) |=> tx_data_out == $past(prbs_bit))
        else $error("prbs bit not sent");
    // code bit reaches the line on each chosen enable
    code_path_a: assert property (@(posedge clock) disable iff (rst)
        (pat_is_code && bit_en) |=> tx_data_out == $past(code_bit))
        else $error("code bit not sent");
    // no enable means the code bit is held, never skipped
    code_hold_a: assert property (@(posedge clock) disable iff (rst)
        (pat_is_code && !bit_en) |=> $stable(tx_data_out))
        else $error("code bit moved without enable");
    // criterion bit written lands on the detector setting
    crit_follow_a: assert property (@(posedge clock) disable iff (rst)
        (wr_en && hit_patt) |=> los_ais_criterion == $past(wdata[2]))
        else $error("criterion not applied");
    // transmit code write lands whole
    tx_code_a: assert property (@(posedge clock) disable iff (rst)
        (wr_en && hit_tx) |=> tx_code_reg == $past(wdata))
        else $error("tx code write lost");
    // activate code write reaches the detector
    act_code_a: assert property (@(posedge clock) disable iff (rst)
        (wr_en && hit_act) |=> rx_activate_code == $past(wdata))
        else $error("activate code write lost");
    // deactivate code write reaches the detector
    deact_code_a: assert property (@(posedge clock) disable iff (rst)
        (wr_en && hit_deact) |=> rx_deactivate_code == $past(wdata))
        else $error("deactivate code write lost");
    // deactivate length written lands in place
    deact_len_a: assert property (@(posedge clock) disable iff (rst)
        (wr_en && hit_len) |=> rx_deactivate_code_length == $past(wdata[1:0]))
        else $error("deactivate length lost");
    // lengths only change on a write
    len_hold_a: assert property (@(posedge clock) disable iff (rst)
        !wr_en |=> $stable(code_length_reg))
        else $error("length changed without write");
    // reserved bits never hold a one
    reserved_zero_a: assert property (@(posedge clock) disable iff (rst)
        !pattern_los_reg[7] && code_length_reg[7:6] == 2'h0)
        else $error("reserved bit set");
    // auto ones never overrides a generated pattern
    auto_scope_a: assert property (@(posedge clock) disable iff (rst)
        pattern_select[1] |-> src_next == maint_pkg::SRC_GEN)
        else $error("auto ones outside normal select");
    // select 01 always picks the ones source
    ones_select_a: assert property (@(posedge clock) disable iff (rst)
        (pattern_select == maint_pkg::PATT_ONES) |-> src_next == maint_pkg::SRC_ONES)
        else $error("ones source not chosen");
    // ones on the master clock follow master enables only
    ones_valid_a: assert property (@(posedge clock) disable iff (rst)
        (pattern_select == 2'h1 && pattern_clock_select) |=> tx_bit_valid == $past(master_clock_en))
        else $error("ones ignore master clock");
    // inserted zeros follow master enables only
    zero_clock_a: assert property (@(posedge clock) disable iff (rst)
        (pattern_select == 2'h0 && pattern_clock_select && !los) |=>
            tx_bit_valid == $past(master_clock_en))
        else $error("zeros ignore master clock");
    // normal data always follows the channel tx clock
    data_clock_a: assert property (@(posedge clock) disable iff (rst)
        (src_next == maint_pkg::SRC_DATA) |=> tx_bit_valid == $past(tx_clock_en))
        else $error("data off tx clock");
    // ais clock rides with the positive rail
    ais_clock_a: assert property (@(posedge clock) disable iff (rst)
        ais_on |=> channel_rx_clock_out == rx_data_positive_out)
        else $error("ais clock wrong");
    // without ais the negative rail and clock pass
    rx_pass_a: assert property (@(posedge clock) disable iff (rst)
        !ais_on |=> rx_data_negative_out == $past(rx_data_negative)
            && channel_rx_clock_out == $past(channel_rx_clock))
        else $error("receive side altered");
endmodule

// ---- bench/line_maint_pattern_ctrl_test.sv ----
// self-checking bench for the maintenance register bank and pattern selector
// assumes the design's defines header and a single 100 MHz clock domain
`timescale 1ns/1ns
`include "maint_defs.svh"
module test_line_maint_pattern_ctrl;
    logic clock, rst, wr_en, rd_en, e1_mode, tx_clock_en, master_clock_en;
    logic [7:0] addr, wdata, rdata;
    logic tx_data_in, tx_data_out, tx_bit_valid, los;
    logic rx_data_positive, rx_data_negative, channel_rx_clock;
    logic rx_data_positive_out, rx_data_negative_out, channel_rx_clock_out;
    logic los_ais_criterion, prbs_invert;
    logic [1:0] rx_activate_code_length, rx_deactivate_code_length;
    logic [7:0] rx_activate_code, rx_deactivate_code;
    int err_total = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic b, p;

    line_maint_pattern_ctrl line_maint_pattern_ctrl_inst (.clock(clock), .rst(rst), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .e1_mode(e1_mode),
        .tx_clock_en(tx_clock_en), .master_clock_en(master_clock_en), .tx_data_in(tx_data_in),
        .tx_data_out(tx_data_out), .tx_bit_valid(tx_bit_valid), .los(los),
        .rx_data_positive(rx_data_positive), .rx_data_negative(rx_data_negative),
        .channel_rx_clock(channel_rx_clock), .rx_data_positive_out(rx_data_positive_out),
        .rx_data_negative_out(rx_data_negative_out), .channel_rx_clock_out(channel_rx_clock_out),
        .los_ais_criterion(los_ais_criterion), .prbs_invert(prbs_invert),
        .rx_activate_code_length(rx_activate_code_length),
        .rx_deactivate_code_length(rx_deactivate_code_length),
        .rx_activate_code(rx_activate_code), .rx_deactivate_code(rx_deactivate_code));

    // 10 ns clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // hang guard: the whole sequence needs well under 2000 cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            stop_test();
        end
    end

    task automatic stop_test();
        if (err_total == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk1(input string name, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %b seen %b", name, exp, got);
        end
    endtask

    // one-cycle write strobe; the trailing edge leaves a gap before the next access
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
        #1;
    endtask

    // rdata stands only in the cycle after the strobe, so sample just past that edge
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1;
        chk8($sformatf("reg %h", a), exp, rdata);
    endtask

    // one bit enable on the chosen reference; valid must pulse only if that reference is live
    task automatic send(input logic m, input logic d, input logic v, output logic bit_out);
        @(posedge clock);
        master_clock_en <= m;
        tx_clock_en <= ~m;
        tx_data_in <= d;
        @(posedge clock);
        master_clock_en <= 1'b0;
        tx_clock_en <= 1'b0;
        #1;
        chk1("tx_bit_valid", v, tx_bit_valid);
        bit_out = tx_data_out;
    endtask

    // code of length n repeated twice, highest selected bit first
    task automatic code_chk(input int n, input logic [7:0] c);
        logic bb;
        for (int i = 0; i < 2 * n; i++) begin
            send(1'b0, 1'b0, 1'b1, bb);
            chk1("code_bit", c[n - 1 - (i % n)], bb);
        end
    endtask

    // a pseudo-random stream must hold both levels within 40 bits
    task automatic prbs_chk();
        logic bb;
        int ones;
        ones = 0;
        for (int i = 0; i < 40; i++) begin
            send(1'b0, 1'b0, 1'b1, bb);
            ones += int'(bb === 1'b1);
        end
        chk1("prbs_mixed", 1'b1, ones > 0 && ones < 40);
    endtask

    // main sequence
    initial begin
        rst = 1'b1;
        {addr, wdata, wr_en, rd_en, e1_mode, tx_clock_en, master_clock_en} = '0;
        {tx_data_in, los, rx_data_positive, rx_data_negative, channel_rx_clock} = '0;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        rd_chk(`ADDR_PATTERN_LOS, 8'h00);
        rd_chk(`ADDR_CODE_LENGTH, 8'h01);
        rd_chk(`ADDR_TX_CODE, 8'h01);
        rd_chk(`ADDR_RX_ACT_CODE, 8'h01);
        rd_chk(`ADDR_RX_DEACT_CODE, 8'h09);
        chk8("deact_len", 8'h01, {6'h00, rx_deactivate_code_length});
        wr(`ADDR_PATTERN_LOS, 8'h60);
        code_chk(5, 8'h01);
        // reserved bits read back as zero, unmapped place ignored
        wr(`ADDR_PATTERN_LOS, 8'hFF);
        rd_chk(`ADDR_PATTERN_LOS, 8'h7F);
        chk1("invert", 1'b1, prbs_invert);
        chk1("criterion", 1'b1, los_ais_criterion);
        wr(`ADDR_PATTERN_LOS, 8'h08);
        chk1("invert", 1'b1, prbs_invert);
        chk1("criterion", 1'b0, los_ais_criterion);
        wr(`ADDR_PATTERN_LOS, 8'h04);
        chk1("invert", 1'b0, prbs_invert);
        chk1("criterion", 1'b1, los_ais_criterion);
        wr(`ADDR_CODE_LENGTH, 8'hFF);
        rd_chk(`ADDR_CODE_LENGTH, 8'h3F);
        chk8("lengths", 8'h0F, {4'h0, rx_activate_code_length, rx_deactivate_code_length});
        wr(`ADDR_RX_ACT_CODE, 8'hC6);
        chk8("act_code", 8'hC6, rx_activate_code);
        wr(`ADDR_RX_DEACT_CODE, 8'h5A);
        chk8("deact_code", 8'h5A, rx_deactivate_code);
        wr(8'h40, 8'hFF);
        rd_chk(8'h40, 8'h00);
        // every transmit code length, restarting on each entry into code mode
        for (int l = 0; l < 4; l++) begin
            wr(`ADDR_PATTERN_LOS, 8'h00);
            wr(`ADDR_CODE_LENGTH, {2'b00, l[1:0], 4'h0});
            wr(`ADDR_TX_CODE, 8'hB3);
            wr(`ADDR_PATTERN_LOS, 8'h60);
            code_chk(l + 5, 8'hB3);
        end
        wr(`ADDR_PATTERN_LOS, 8'h00);
        for (int i = 0; i < 4; i++) begin
            send(1'b0, i[0], 1'b1, b);
            chk1("tx_data", i[0], b);
        end
        wr(`ADDR_PATTERN_LOS, 8'h10);
        send(1'b1, 1'b1, 1'b1, b);
        chk1("zeros", 1'b0, b);
        send(1'b0, 1'b1, 1'b0, b);
        wr(`ADDR_PATTERN_LOS, 8'h20);
        send(1'b0, 1'b0, 1'b1, b);
        chk1("ones", 1'b1, b);
        rd_chk(`ADDR_STATUS, 8'h04);
        wr(`ADDR_PATTERN_LOS, 8'h30);
        send(1'b1, 1'b0, 1'b1, b);
        chk1("ones", 1'b1, b);
        send(1'b0, 1'b0, 1'b0, b);
        // all ones on los only while the select field is 00
        wr(`ADDR_PATTERN_LOS, 8'h01);
        @(posedge clock) los <= 1'b1;
        send(1'b0, 1'b0, 1'b1, b);
        chk1("auto_ones", 1'b1, b);
        wr(`ADDR_PATTERN_LOS, 8'h11);
        send(1'b1, 1'b0, 1'b1, b);
        chk1("auto_ones", 1'b1, b);
        wr(`ADDR_PATTERN_LOS, 8'h61);
        code_chk(8, 8'hB3);
        wr(`ADDR_PATTERN_LOS, 8'h00);
        send(1'b0, 1'b0, 1'b1, b);
        chk1("no_auto", 1'b0, b);
        @(posedge clock) los <= 1'b0;
        // both generator lengths; the 2^15-1 one plain and inverted, the qrss one inverted only
        wr(`ADDR_PATTERN_LOS, 8'h40);
        @(posedge clock) e1_mode <= 1'b1;
        prbs_chk();
        wr(`ADDR_PATTERN_LOS, 8'h48);
        prbs_chk();
        @(posedge clock) e1_mode <= 1'b0;
        prbs_chk();
        // receive ais: inputs chosen so they never look like the ais pattern
        wr(`ADDR_PATTERN_LOS, 8'h02);
        @(posedge clock);
        rx_data_positive <= 1'b1;
        rx_data_negative <= 1'b1;
        los <= 1'b1;
        repeat (3) @(posedge clock);
        #1;
        p = rx_data_positive_out;
        chk1("ais_neg", ~p, rx_data_negative_out);
        chk1("ais_clk", p, channel_rx_clock_out);
        @(posedge clock);
        #1;
        chk1("ais_alt", ~p, rx_data_positive_out);
        wr(`ADDR_PATTERN_LOS, 8'h00);
        repeat (3) @(posedge clock);
        #1;
        chk8("rx_pass", 8'h07, {5'h00, rx_data_positive_out, rx_data_negative_out,
            ~channel_rx_clock_out});
        stop_test();
    end
endmodule
